// ---- ipc_card_cfg.sv ----
// Card configuration state machine with resource registers
`timescale 1ns/1ps
module ipc_card_cfg (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rstdrv_i,
  input  wire logic        addr_wr_i,
  input  wire logic        data_wr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        data_rd_i,
  input  wire logic        ee_load_i,
  input  wire logic [15:0] ee_io_base_i,
  input  wire logic [7:0]  ee_rom_base_i,
  input  wire logic [3:0]  ee_irq_i,
  input  wire logic [1:0]  ee_rom_size_i,
  input  wire logic [7:0]  ee_mode_i,
  output logic [7:0]       rdata_o,
  output logic [3:0]       state_o,
  output logic [7:0]       csn_o,
  output logic [1:0]       mode_o,
  output logic [15:0]      io_base_o,
  output logic [7:0]       rom_base_o,
  output logic [3:0]       irq_o,
  output logic [1:0]       rom_size_o
);
  ipc_pkg::ipc_state_t state_r, state_nxt;
  ipc_pkg::ipc_mode_t  mode_r, mode_nxt;
  logic [7:0]  csn_nxt, idx_r, idx_nxt, pend_mode_r, pend_mode_nxt, rdata_nxt;
  logic [15:0] io_nxt, ee_io_r, ee_io_nxt;
  logic [7:0]  rom_nxt, ee_rom_r, ee_rom_nxt;
  logic [3:0]  irq_nxt, ee_irq_r, ee_irq_nxt;
  logic [1:0]  size_nxt, ee_size_r, ee_size_nxt;
  logic        std_hit, vend_hit, in_wfk, std_ok;

  assign in_wfk = (state_r == ipc_pkg::IPC_WFK);
  assign std_ok = (mode_r != ipc_pkg::IPC_MODE_JMP);

  // Key recognisers watch address port writes made in Wait for Key only
  ipc_key_match #(
    .SEED (ipc_pkg::STD_KEY_SEED)
  ) u_std_key (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .wr_i   (addr_wr_i & in_wfk),
    .data_i (wdata_i),
    .hit_o  (std_hit)
  );

  ipc_key_match #(
    .SEED (ipc_pkg::VEND_KEY_SEED)
  ) u_vend_key (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .wr_i   (addr_wr_i & in_wfk),
    .data_i (wdata_i),
    .hit_o  (vend_hit)
  );

  // Next-state, card number, mode and resource logic
  always_comb begin
    state_nxt     = state_r;
    mode_nxt      = mode_r;
    csn_nxt       = csn_o;
    idx_nxt       = idx_r;
    pend_mode_nxt = pend_mode_r;
    rdata_nxt     = rdata_o;
    io_nxt        = io_base_o;
    rom_nxt       = rom_base_o;
    irq_nxt       = irq_o;
    size_nxt      = rom_size_o;
    ee_io_nxt     = ee_io_r;
    ee_rom_nxt    = ee_rom_r;
    ee_irq_nxt    = ee_irq_r;
    ee_size_nxt   = ee_size_r;
    if (addr_wr_i) begin
      idx_nxt = wdata_i;
    end
    if (ee_load_i) begin
      ee_io_nxt     = ee_io_base_i;
      ee_rom_nxt    = ee_rom_base_i;
      ee_irq_nxt    = ee_irq_i;
      ee_size_nxt   = ee_rom_size_i;
      pend_mode_nxt = ee_mode_i;
      io_nxt        = ee_io_base_i;
      rom_nxt       = ee_rom_base_i;
      irq_nxt       = ee_irq_i;
      size_nxt      = ee_rom_size_i;
    end
    if (rstdrv_i) begin
      state_nxt = ipc_pkg::IPC_WFK;
      csn_nxt   = 8'h00;
      mode_nxt  = ipc_pkg::mode_dec(pend_mode_r);
      io_nxt    = ee_io_r;
      rom_nxt   = ee_rom_r;
      irq_nxt   = ee_irq_r;
      size_nxt  = ee_size_r;
    end else begin
      if (in_wfk && vend_hit) begin
        state_nxt = ipc_pkg::IPC_CFG;
      end else if (in_wfk && std_hit && std_ok) begin
        state_nxt = ipc_pkg::IPC_SLEEP;
      end
      if (data_wr_i && !in_wfk) begin
        unique case (idx_r)
          ipc_pkg::REG_CFG_CTRL: begin
            if (wdata_i[ipc_pkg::CTRL_WFK_BIT]) begin
              state_nxt = ipc_pkg::IPC_WFK;
            end
            if (wdata_i[ipc_pkg::CTRL_CLR_BIT]) begin
              csn_nxt = 8'h00;
            end
          end
          ipc_pkg::REG_VEND_CLR: begin
            csn_nxt = 8'h00;
          end
          ipc_pkg::REG_WAKE: begin
            if (wdata_i == csn_o) begin
              if (state_r == ipc_pkg::IPC_SLEEP) begin
                state_nxt = (csn_o == 8'h00) ? ipc_pkg::IPC_ISO : ipc_pkg::IPC_CFG;
              end
            end else if (state_r != ipc_pkg::IPC_SLEEP) begin
              state_nxt = ipc_pkg::IPC_SLEEP;
            end
          end
          ipc_pkg::REG_CSN: begin
            if (state_r == ipc_pkg::IPC_ISO) begin
              csn_nxt   = wdata_i;
              state_nxt = ipc_pkg::IPC_CFG;
            end
          end
          ipc_pkg::REG_IO_HI: begin
            if (state_r == ipc_pkg::IPC_CFG) io_nxt[15:8] = wdata_i;
          end
          ipc_pkg::REG_IO_LO: begin
            if (state_r == ipc_pkg::IPC_CFG) io_nxt[7:0] = wdata_i;
          end
          ipc_pkg::REG_MEM_HI: begin
            if (state_r == ipc_pkg::IPC_CFG) rom_nxt = wdata_i;
          end
          ipc_pkg::REG_IRQ: begin
            if (state_r == ipc_pkg::IPC_CFG) irq_nxt = wdata_i[3:0];
          end
          default: begin
          end
        endcase
      end
    end
    // Read port shows the logical device copies of the resources
    if (data_rd_i) begin
      unique case (idx_r)
        ipc_pkg::REG_CSN:      rdata_nxt = csn_o;
        ipc_pkg::REG_IO_HI:    rdata_nxt = io_base_o[15:8];
        ipc_pkg::REG_IO_LO:    rdata_nxt = io_base_o[7:0];
        ipc_pkg::REG_MEM_HI:   rdata_nxt = rom_base_o;
        ipc_pkg::REG_IRQ:      rdata_nxt = {4'h0, irq_o};
        ipc_pkg::REG_ROM_SIZE: rdata_nxt = {6'h00, rom_size_o};
        default:               rdata_nxt = 8'h00;
      endcase
      if (state_r != ipc_pkg::IPC_CFG) rdata_nxt = 8'h00;
    end
  end

  // Register stage; power-on starts jumperless in Wait for Key
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= ipc_pkg::IPC_WFK;
      mode_r      <= ipc_pkg::IPC_MODE_JMP;
      csn_o       <= 8'h00;
      idx_r       <= 8'h00;
      pend_mode_r <= ipc_pkg::MODE_BYTE_JMP;
      rdata_o     <= 8'h00;
      io_base_o   <= 16'h0000;
      rom_base_o  <= 8'h00;
      irq_o       <= 4'h0;
      rom_size_o  <= 2'h0;
      ee_io_r     <= 16'h0000;
      ee_rom_r    <= 8'h00;
      ee_irq_r    <= 4'h0;
      ee_size_r   <= 2'h0;
      state_o     <= ipc_pkg::IPC_WFK;
      mode_o      <= ipc_pkg::IPC_MODE_JMP;
    end else begin
      state_r     <= state_nxt;
      mode_r      <= mode_nxt;
      csn_o       <= csn_nxt;
      idx_r       <= idx_nxt;
      pend_mode_r <= pend_mode_nxt;
      rdata_o     <= rdata_nxt;
      io_base_o   <= io_nxt;
      rom_base_o  <= rom_nxt;
      irq_o       <= irq_nxt;
      rom_size_o  <= size_nxt;
      ee_io_r     <= ee_io_nxt;
      ee_rom_r    <= ee_rom_nxt;
      ee_irq_r    <= ee_irq_nxt;
      ee_size_r   <= ee_size_nxt;
      state_o     <= state_nxt;
      mode_o      <= mode_nxt;
    end
  end

  // Checks on the state machine and resources
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RSTDRV_WFK: assert property (rstdrv_i |=> state_o == ipc_pkg::IPC_WFK && csn_o == 8'h00)
    else $error("Bus reset did not force wait for key");
  AST_RSTDRV_RESTORE: assert property (rstdrv_i && !ee_load_i |=> io_base_o == $past(ee_io_r))
    else $error("Bus reset did not restore io base");
  AST_VEND_KEY: assert property (in_wfk && vend_hit && !rstdrv_i |=> state_r == ipc_pkg::IPC_CFG)
    else $error("Vendor key did not enter config");
  AST_STD_KEY_JMP: assert property (mode_r == ipc_pkg::IPC_MODE_JMP && in_wfk && !vend_hit
      |=> state_r != ipc_pkg::IPC_SLEEP)
    else $error("Standard key accepted in jumperless mode");
  AST_MODE_HOLD: assert property (!rstdrv_i |=> $stable(mode_r))
    else $error("Mode changed without hardware reset");
  AST_CLR_NO_MOVE: assert property (data_wr_i && idx_r == ipc_pkg::REG_VEND_CLR && !in_wfk
      && !rstdrv_i |=> csn_o == 8'h00 && $stable(state_r))
    else $error("Vendor card number clear misbehaved");
  AST_WFK_CMD: assert property (data_wr_i && idx_r == ipc_pkg::REG_CFG_CTRL && !in_wfk
      && wdata_i[ipc_pkg::CTRL_WFK_BIT] |=> state_r == ipc_pkg::IPC_WFK)
    else $error("Wait for key command ignored");
  AST_SIZE_FIXED: assert property (!ee_load_i && !rstdrv_i |=> $stable(rom_size_o))
    else $error("Boot ROM size changed by software");
  AST_CFG_WRITE: assert property (data_wr_i && idx_r == ipc_pkg::REG_IRQ
      && state_r == ipc_pkg::IPC_CFG && !rstdrv_i && !ee_load_i
      |=> irq_o == $past(wdata_i[3:0]))
    else $error("Irq write not mirrored");
  AST_ONE_HOT: assert property ($onehot(state_r))
    else $error("State not one-hot");
endmodule

// ---- ipc_card_cfg_test.sv ----
// Self-checking bench for the card configuration state block
`timescale 1ns/1ps
module ipc_card_cfg_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rstdrv = 1'b0;
  logic        ee_load = 1'b0;
  logic [15:0] ee_io = 16'h0300;
  logic [7:0]  ee_rb = 8'hC8;
  logic [3:0]  ee_irq = 4'h3;
  logic [1:0]  ee_rs = 2'h2;
  logic [7:0]  ee_mode = 8'h50;
  logic        aw, dw, dr;
  logic [7:0]  wd, rdata, csn, rom_base;
  logic [3:0]  state, irq;
  logic [1:0]  mode, rom_size;
  logic [15:0] io_base;
  int          fail_count = 0;
  int          comparisons = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  ipc_host_model i_host (.clk_i(clk), .addr_wr_o(aw), .data_wr_o(dw), .data_rd_o(dr),
    .wdata_o(wd));

  ipc_card_cfg i_dut (.clk_i(clk), .rst_i(rst), .rstdrv_i(rstdrv), .addr_wr_i(aw),
    .data_wr_i(dw), .wdata_i(wd), .data_rd_i(dr), .ee_load_i(ee_load),
    .ee_io_base_i(ee_io), .ee_rom_base_i(ee_rb), .ee_irq_i(ee_irq),
    .ee_rom_size_i(ee_rs), .ee_mode_i(ee_mode), .rdata_o(rdata), .state_o(state),
    .csn_o(csn), .mode_o(mode), .io_base_o(io_base), .rom_base_o(rom_base),
    .irq_o(irq), .rom_size_o(rom_size));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Register write: index then value
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
    i_host.access(0, idx);
    i_host.access(1, v);
  endtask

  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
    i_host.access(0, idx);
    i_host.access(2, 8'h00);
    chk(rdata, exp);
  endtask

  task automatic send_key(input logic [7:0] seed);
    i_host.key(seed);
    idle(2);
  endtask

  // Bus reset pulse, then let it land
  task automatic bus_reset;
    @(negedge clk);
    rstdrv = 1'b1;
    @(negedge clk);
    rstdrv = 1'b0;
    idle(2);
  endtask

  // Isolation then card number assignment
  task automatic assign_csn(input logic [7:0] v);
    reg_wr(8'h03, 8'h01);
    chk(state, 4'h2);
    reg_wr(8'h03, 8'h00);
    chk(state, 4'h4);
    reg_wr(8'h06, v);
    chk(csn, v);
  endtask

  // State right after power-on reset
  task automatic t_reset;
    chk(state, 4'h1);
    chk(mode, 2'h0);
    chk(csn, 8'h00);
  endtask

  task automatic t_eeprom;
    @(negedge clk);
    ee_load = 1'b1;
    @(negedge clk);
    ee_load = 1'b0;
    idle(1);
    chk(io_base, 16'h0300);
    chk(rom_base, 8'hC8);
    chk(irq, 4'h3);
    chk(mode, 2'h0);
  endtask

  task automatic t_keys;
    send_key(ipc_pkg::STD_KEY_SEED);
    chk(state, 4'h1);
    send_key(ipc_pkg::VEND_KEY_SEED);
    chk(state, 4'h8);
  endtask

  task automatic t_config;
    reg_wr(8'h70, 8'h05);
    chk(irq, 4'h5);
    reg_wr(8'h60, 8'h12);
    reg_wr(8'h61, 8'h40);
    chk(io_base, 16'h1240);
    reg_rd(8'h70, 8'h05);
    reg_wr(8'hF0, 8'h01);
    chk(rom_size, 2'h2);
    reg_rd(8'hF0, 8'h02);
    reg_rd(8'h55, 8'h00);
  endtask

  task automatic t_csn;
    assign_csn(8'h07);
    reg_wr(8'h02, 8'h04);
    chk(csn, 8'h00);
    chk(state, 4'h8);
    assign_csn(8'h03);
    reg_wr(8'h24, 8'h00);
    chk(csn, 8'h00);
    chk(state, 4'h8);
    reg_wr(8'h02, 8'h02);
    chk(state, 4'h1);
  endtask

  task automatic t_bus_reset;
    send_key(ipc_pkg::VEND_KEY_SEED);
    assign_csn(8'h09);
    reg_wr(8'h70, 8'h0A);
    bus_reset();
    chk(state, 4'h1);
    chk(csn, 8'h00);
    chk(irq, 4'h3);
    chk(io_base, 16'h0300);
    chk(mode, 2'h1);
    // Outside Config a resource write is ignored and reads return zero
    reg_wr(8'h70, 8'h0C);
    chk(irq, 4'h3);
    reg_rd(8'h70, 8'h00);
    send_key(ipc_pkg::STD_KEY_SEED);
    chk(state, 4'h2);
  endtask

  // Each remaining mode byte, adopted only at the bus reset
  task automatic t_modes;
    logic [7:0] mb [2] = '{8'h4A, 8'h33};
    logic [1:0] em [2] = '{2'h0, 2'h2};
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      ee_mode = mb[i];
      ee_load = 1'b1;
      @(negedge clk);
      ee_load = 1'b0;
      idle(1);
      chk(mode, (i == 0) ? 2'h1 : 2'h0);
      bus_reset();
      chk(mode, em[i]);
    end
  endtask

  // Main sequence
  initial begin
    idle(8);
    rst = 1'b0;
    idle(1);
    t_reset();
    t_eeprom();
    t_keys();
    t_config();
    t_csn();
    t_bus_reset();
    t_modes();
    end_sim();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200us;
    fail_count++;
    end_sim();
  end
endmodule

// ---- ipc_host_model.sv ----
// Host software model issuing configuration port accesses
`timescale 1ns/1ps
module ipc_host_model (
  input  wire logic       clk_i,
  output logic            addr_wr_o,
  output logic            data_wr_o,
  output logic            data_rd_o,
  output logic [7:0]      wdata_o
);
  // Idle bus at time zero
  initial begin
    addr_wr_o = 1'b0;
    data_wr_o = 1'b0;
    data_rd_o = 1'b0;
    wdata_o   = 8'h00;
  end

  // One access: 0 address write, 1 data write, 2 read; strobe spans one rising edge
  task automatic access(input int kind, input logic [7:0] v);
    @(negedge clk_i);
    wdata_o   = v;
    addr_wr_o = (kind == 0);
    data_wr_o = (kind == 1);
    data_rd_o = (kind == 2);
    @(negedge clk_i);
    addr_wr_o = 1'b0;
    data_wr_o = 1'b0;
    data_rd_o = 1'b0;
    wdata_o   = ~v; // Released data never shows the last value
  endtask

  // Key: back-to-back address writes of the generator sequence
  task automatic key(input logic [7:0] seed);
    logic [7:0] v;
    v = seed;
    @(negedge clk_i);
    addr_wr_o = 1'b1;
    for (int i = 0; i < 32; i++) begin
      wdata_o = v;
      v = {v[1] ^ v[0], v[7:1]};
      @(negedge clk_i);
    end
    addr_wr_o = 1'b0;
    wdata_o   = ~v;
  endtask
endmodule

// ---- ipc_key_match.sv ----
// Initiation key recogniser for address port writes
`timescale 1ns/1ps
module ipc_key_match #(
  parameter logic [7:0] SEED = 8'h6A
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] data_i,
  output logic            hit_o
);
  logic [7:0] lfsr_r, lfsr_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic       hit_nxt;

  // Track the key byte sequence; a wrong byte restarts the search
  always_comb begin
    lfsr_nxt = lfsr_r;
    cnt_nxt  = cnt_r;
    hit_nxt  = 1'b0;
    if (wr_i) begin
      if (data_i == lfsr_r) begin
        if (cnt_r == 6'(ipc_pkg::KEY_LEN - 1)) begin
          hit_nxt  = 1'b1;
          cnt_nxt  = 6'h00;
          lfsr_nxt = SEED;
        end else begin
          cnt_nxt  = cnt_r + 6'h01;
          lfsr_nxt = ipc_pkg::lfsr_next(lfsr_r);
        end
      end else if (data_i == SEED) begin
        cnt_nxt  = 6'h01;
        lfsr_nxt = ipc_pkg::lfsr_next(SEED);
      end else begin
        cnt_nxt  = 6'h00;
        lfsr_nxt = SEED;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_r <= SEED;
      cnt_r  <= 6'h00;
      hit_o  <= 1'b0;
    end else begin
      lfsr_r <= lfsr_nxt;
      cnt_r  <= cnt_nxt;
      hit_o  <= hit_nxt;
    end
  end
endmodule

// ---- ipc_pkg.sv ----
// Constants and shared logic for the card configuration state block
// Operation
// - After power-on the card starts in jumperless mode.
// - Resource values live in resource and logical device registers alike.
// - Resource power-up defaults come from the serial EEPROM in every mode.
// - Software writes resource values in config state; the EEPROM resource copies do not follow.
// - Bus reset discards software changes and restores EEPROM values.
// - Boot ROM size is never writable by software.
// - Vendor key works in all modes; standard key only outside jumperless.
// - Vendor key moves the card straight to Config, even when jumperless.
// - State machine has Wait for Key, Sleep, Isolation and Config.
// - Bus reset forces Wait for Key and clears the card number.
// - Wait for Key command returns to Wait for Key from any state.
// - Standard and vendor card number clear commands zero the card number.
// - Card number clear commands never change the state.
// - Mode byte 4A is jumperless, 50 is plug and play, else auto.
// - New operation mode is adopted only at a hardware reset.
package ipc_pkg;
  typedef enum logic [3:0] {
    IPC_WFK   = 4'h1,
    IPC_SLEEP = 4'h2,
    IPC_ISO   = 4'h4,
    IPC_CFG   = 4'h8
  } ipc_state_t;

  typedef enum logic [1:0] {
    IPC_MODE_JMP  = 2'h0,
    IPC_MODE_PNP  = 2'h1,
    IPC_MODE_AUTO = 2'h2
  } ipc_mode_t;

  localparam logic [7:0] MODE_BYTE_JMP  = 8'h4A;
  localparam logic [7:0] MODE_BYTE_PNP  = 8'h50;
  localparam int         KEY_LEN        = 32;
  localparam logic [7:0] STD_KEY_SEED   = 8'h6A;
  localparam logic [7:0] VEND_KEY_SEED  = 8'h3C; // Arbitrary value
  // Card control register indexes
  localparam logic [7:0] REG_CFG_CTRL   = 8'h02;
  localparam logic [7:0] REG_WAKE       = 8'h03;
  localparam logic [7:0] REG_CSN        = 8'h06;
  localparam logic [7:0] REG_VEND_CLR   = 8'h24;
  localparam logic [7:0] REG_MEM_HI     = 8'h40;
  localparam logic [7:0] REG_IO_HI      = 8'h60;
  localparam logic [7:0] REG_IO_LO      = 8'h61;
  localparam logic [7:0] REG_IRQ        = 8'h70;
  localparam logic [7:0] REG_ROM_SIZE   = 8'hF0;
  localparam int         CTRL_WFK_BIT   = 1;
  localparam int         CTRL_CLR_BIT   = 2;

  // Next value of the key generator
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    lfsr_next = {v[1] ^ v[0], v[7:1]};
  endfunction

  // Mode byte decode
  function automatic ipc_mode_t mode_dec(input logic [7:0] b);
    if (b == MODE_BYTE_JMP) mode_dec = IPC_MODE_JMP;
    else if (b == MODE_BYTE_PNP) mode_dec = IPC_MODE_PNP;
    else mode_dec = IPC_MODE_AUTO;
  endfunction
endpackage
